// File: verilog/ftm_pkg.sv
package ftm_pkg;
    localparam int unsigned CLK_HZ = 200000000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned MS_CYCLES_DFLT = CLK_HZ / MS_PER_S;
    localparam int unsigned DIV_W = 20;
    localparam int unsigned HOLD_BASE_S = 2;
    localparam int unsigned HOLD_MAX_S = 64;
    localparam int unsigned HOLD_W = 17;
    localparam int unsigned COMM_W = 16;
    localparam int unsigned REP_W = 3;
    localparam logic [REP_W-1:0] REP_MAX = 3'h5;
    localparam logic [HOLD_W-1:0] HOLD_BASE_MS =
        17'(HOLD_BASE_S * MS_PER_S);
    localparam logic [HOLD_W-1:0] HOLD_MAX_MS =
        17'(HOLD_MAX_S * MS_PER_S);

    localparam logic [7:0] CODE_NONE = 8'h00;
    localparam logic [7:0] CODE_OVERCURRENT = 8'h03;
    localparam logic [7:0] CODE_OVERLOAD = 8'h04;
    localparam logic [7:0] CODE_HOLD5 = 8'h05;
    localparam logic [7:0] CODE_UNDER_TEMP = 8'h09;
    localparam logic [7:0] CODE_EXT_CONTACT = 8'h0B;
    localparam logic [7:0] CODE_BUS_RIPPLE = 8'h0D;
    localparam logic [7:0] CODE_PHASE_LOSS = 8'h0E;
    localparam logic [7:0] CODE_HW_OVERCURRENT = 8'h0F;
    localparam logic [7:0] CODE_HEATSINK_SENSOR = 8'h10;
    localparam logic [7:0] CODE_MEM_IO = 8'h11;
    localparam logic [7:0] CODE_MEM_DSP = 8'h13;
    localparam logic [7:0] CODE_MOTOR_PTC = 8'h15;
    localparam logic [7:0] CODE_FAN = 8'h16;
    localparam logic [7:0] CODE_OVERHEAT = 8'h17;
    localparam logic [7:0] CODE_OUTPUT_PHASE = 8'h1A;
    localparam logic [7:0] CODE_TUNING = 8'h29;
    localparam logic [7:0] CODE_SERIAL_TMO = 8'h32;
    localparam logic [7:0] CODE_CAN_TMO = 8'h33;

    typedef struct packed {
        logic tripped;
        logic [7:0] code;
        logic runPermit;
        logic holdActive;
        logic [REP_W-1:0] repeatCnt;
        logic [HOLD_W-1:0] holdCnt;
        logic [DIV_W-1:0] msDiv;
        logic msTick;
        logic [COMM_W-1:0] serialCnt;
        logic [COMM_W-1:0] canCnt;
        logic enablePrev;
        logic keyPrev;
        logic resetBitPrev;
    } ftm_state_t;
endpackage : ftm_pkg

// File: verilog/ftm_fault_trip_manager.sv
`timescale 1ns/10ps
module ftm_fault_trip_manager #(
    parameter int unsigned MS_CYCLES = ftm_pkg::MS_CYCLES_DFLT,
    parameter bit ENCLOSED = 1'b1
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic overCurrent,
    input wire logic motorOverload,
    input wire logic hwOverCurrent,
    input wire logic ambientLow,
    input wire logic din3Closed,
    input wire logic busRippleHigh,
    input wire logic inputPhaseLost,
    input wire logic heatsinkSensorBad,
    input wire logic memFaultIo,
    input wire logic memFaultDsp,
    input wire logic motorPtcHot,
    input wire logic fanFailed,
    input wire logic internalHot,
    input wire logic outputPhaseBad,
    input wire logic tuningBad,
    input wire logic serialActive,
    input wire logic serialPoll,
    input wire logic canActive,
    input wire logic canCyclic,
    input wire logic [ftm_pkg::COMM_W-1:0] commTimeoutMs,
    input wire logic driveEnable,
    input wire logic stopKey,
    input wire logic fieldbusMode,
    input wire logic ctrlResetBit,
    output logic tripped,
    output logic [7:0] faultCode,
    output logic driveStop,
    output logic runPermit,
    output logic holdOffActive
);
    // Elaboration checks
    initial
    begin
        if (MS_CYCLES < 2 || MS_CYCLES >= (1 << ftm_pkg::DIV_W))
        begin
            $error("MS_CYCLES out of range");
        end
        if ((ftm_pkg::HOLD_MAX_S * ftm_pkg::MS_PER_S) >= (1 << ftm_pkg::HOLD_W))
        begin
            $error("hold-off counter too narrow");
        end
        if ((ftm_pkg::HOLD_BASE_S << ftm_pkg::REP_MAX) != ftm_pkg::HOLD_MAX_S)
        begin
            $error("hold-off schedule inconsistent");
        end
    end

    ftm_pkg::ftm_state_t st_ff;
    ftm_pkg::ftm_state_t nxt_st;

    localparam logic [ftm_pkg::DIV_W-1:0] MS_LAST =
        ftm_pkg::DIV_W'(MS_CYCLES - 1);

    // First active condition in fixed priority order
    function automatic logic [7:0] pick_code(input logic [16:0] f);
        logic [7:0] c;
        c = ftm_pkg::CODE_NONE;
        if (f[0])
        begin
            c = ftm_pkg::CODE_OVERCURRENT;
        end
        else if (f[1])
        begin
            c = ftm_pkg::CODE_HW_OVERCURRENT;
        end
        else if (f[2])
        begin
            c = ftm_pkg::CODE_OVERLOAD;
        end
        else if (f[3])
        begin
            c = ftm_pkg::CODE_PHASE_LOSS;
        end
        else if (f[4])
        begin
            c = ftm_pkg::CODE_BUS_RIPPLE;
        end
        else if (f[5])
        begin
            c = ftm_pkg::CODE_OUTPUT_PHASE;
        end
        else if (f[6])
        begin
            c = ftm_pkg::CODE_OVERHEAT;
        end
        else if (f[7])
        begin
            c = ftm_pkg::CODE_HEATSINK_SENSOR;
        end
        else if (f[8])
        begin
            c = ftm_pkg::CODE_FAN;
        end
        else if (f[9])
        begin
            c = ftm_pkg::CODE_MOTOR_PTC;
        end
        else if (f[10])
        begin
            c = ftm_pkg::CODE_EXT_CONTACT;
        end
        else if (f[11])
        begin
            c = ftm_pkg::CODE_UNDER_TEMP;
        end
        else if (f[12])
        begin
            c = ftm_pkg::CODE_MEM_IO;
        end
        else if (f[13])
        begin
            c = ftm_pkg::CODE_MEM_DSP;
        end
        else if (f[14])
        begin
            c = ftm_pkg::CODE_TUNING;
        end
        else if (f[15])
        begin
            c = ftm_pkg::CODE_SERIAL_TMO;
        end
        else if (f[16])
        begin
            c = ftm_pkg::CODE_CAN_TMO;
        end
        return c;
    endfunction : pick_code

    function automatic logic is_hold_code(input logic [7:0] c);
        return c == ftm_pkg::CODE_OVERCURRENT ||
            c == ftm_pkg::CODE_OVERLOAD ||
            c == ftm_pkg::CODE_HOLD5 ||
            c == ftm_pkg::CODE_HW_OVERCURRENT;
    endfunction : is_hold_code

    logic [16:0] faultVec;
    logic [7:0] newCode;
    logic serialTmo;
    logic canTmo;
    logic resetReq;
    logic clearNow;
    logic [ftm_pkg::HOLD_W-1:0] holdLoad;

    always_comb
    begin
        nxt_st = st_ff;
        // Watchdog flags and fault priority
        serialTmo = serialActive && commTimeoutMs != '0 &&
            st_ff.serialCnt >= commTimeoutMs;
        canTmo = canActive && commTimeoutMs != '0 &&
            st_ff.canCnt >= commTimeoutMs;
        faultVec[0] = overCurrent;
        faultVec[1] = hwOverCurrent;
        faultVec[2] = motorOverload;
        faultVec[3] = inputPhaseLost;
        faultVec[4] = busRippleHigh;
        faultVec[5] = outputPhaseBad;
        faultVec[6] = internalHot;
        faultVec[7] = heatsinkSensorBad;
        faultVec[8] = fanFailed && ENCLOSED;
        faultVec[9] = motorPtcHot;
        faultVec[10] = !din3Closed;
        faultVec[11] = ambientLow;
        faultVec[12] = memFaultIo;
        faultVec[13] = memFaultDsp;
        faultVec[14] = tuningBad;
        faultVec[15] = serialTmo;
        faultVec[16] = canTmo;
        newCode = pick_code(faultVec);

        // Millisecond tick divider
        nxt_st.msTick = 1'b0;
        if (st_ff.msDiv == MS_LAST)
        begin
            nxt_st.msDiv = '0;
            nxt_st.msTick = 1'b1;
        end
        else
        begin
            nxt_st.msDiv = st_ff.msDiv + 1'b1;
        end

        // Communication watchdogs
        if (!serialActive || serialPoll)
        begin
            nxt_st.serialCnt = '0;
        end
        else if (st_ff.msTick && st_ff.serialCnt != '1)
        begin
            nxt_st.serialCnt = st_ff.serialCnt + 1'b1;
        end
        if (!canActive || canCyclic)
        begin
            nxt_st.canCnt = '0;
        end
        else if (st_ff.msTick && st_ff.canCnt != '1)
        begin
            nxt_st.canCnt = st_ff.canCnt + 1'b1;
        end

        // Hold-off countdown
        if (st_ff.holdCnt != '0 && st_ff.msTick)
        begin
            nxt_st.holdCnt = st_ff.holdCnt - 1'b1;
        end

        // Reset requests, edge detected
        nxt_st.enablePrev = driveEnable;
        nxt_st.keyPrev = stopKey;
        nxt_st.resetBitPrev = ctrlResetBit;
        resetReq = (driveEnable && !st_ff.enablePrev) ||
            (stopKey && !st_ff.keyPrev) ||
            (fieldbusMode && ctrlResetBit &&
            !st_ff.resetBitPrev);
        clearNow = st_ff.tripped && resetReq &&
            st_ff.holdCnt == '0;

        // Hold-off reload for this trip
        holdLoad = ftm_pkg::HOLD_BASE_MS << st_ff.repeatCnt;
        if (st_ff.repeatCnt >= ftm_pkg::REP_MAX)
        begin
            holdLoad = ftm_pkg::HOLD_MAX_MS;
        end

        // Clear on accepted request
        if (clearNow)
        begin
            nxt_st.tripped = 1'b0;
            nxt_st.code = ftm_pkg::CODE_NONE;
        end
        // New fault latches only when free; set wins over clear
        if ((!st_ff.tripped || clearNow) && newCode != ftm_pkg::CODE_NONE)
        begin
            nxt_st.tripped = 1'b1;
            nxt_st.code = newCode;
            if (is_hold_code(newCode))
            begin
                nxt_st.holdCnt = holdLoad + 1'b1;
                if (st_ff.repeatCnt < ftm_pkg::REP_MAX)
                begin
                    nxt_st.repeatCnt = st_ff.repeatCnt + 1'b1;
                end
            end
        end

        // Permit and hold flags
        nxt_st.holdActive = nxt_st.holdCnt != '0;
        nxt_st.runPermit = !nxt_st.tripped && !ambientLow &&
            driveEnable;
    end

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            st_ff <= '0;
            st_ff.enablePrev <= 1'b1;
            st_ff.keyPrev <= 1'b1;
            st_ff.resetBitPrev <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Registered outputs
    assign tripped = st_ff.tripped;
    assign faultCode = st_ff.code;
    assign driveStop = st_ff.tripped;
    assign runPermit = st_ff.runPermit;
    assign holdOffActive = st_ff.holdActive;
endmodule : ftm_fault_trip_manager

// File: testbench/ftm_trip_monitor.sv
`timescale 1ns/10ps
module ftm_trip_monitor (
    input wire logic mclk, resetn, overCurrent, motorOverload,
    input wire logic hwOverCurrent, ambientLow, din3Closed,
    input wire logic busRippleHigh, inputPhaseLost, heatsinkSensorBad,
    input wire logic memFaultIo, memFaultDsp, motorPtcHot, fanFailed,
    input wire logic internalHot, outputPhaseBad, tuningBad,
    input wire logic serialActive, canActive, driveEnable, stopKey,
    input wire logic fieldbusMode, ctrlResetBit, tripped, driveStop,
    input wire logic runPermit, holdOffActive,
    input wire logic [7:0] faultCode
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    wire logic quiet = !(overCurrent | motorOverload | hwOverCurrent |
        ambientLow | !din3Closed | busRippleHigh | inputPhaseLost |
        heatsinkSensorBad | memFaultIo | memFaultDsp | motorPtcHot |
        fanFailed | internalHot | outputPhaseBad | tuningBad |
        serialActive | canActive);
    // Latched fault, hold-off over, nothing pending
    sequence s_clearable;
        tripped && !holdOffActive && quiet;
    endsequence
    a_stop_tracks: assert property (driveStop == tripped)
        else $error("driveStop differs from tripped");
    a_trip_norun: assert property (tripped |-> !runPermit)
        else $error("run permitted while tripped");
    a_first_only: assert property (tripped && !$rose(stopKey) &&
        !$rose(driveEnable) && !$rose(ctrlResetBit) |=> $stable(faultCode))
        else $error("latched code changed");
    a_oc_latch: assert property (!tripped && overCurrent |=>
        (tripped && faultCode == 8'h03 && holdOffActive)[*8])
        else $error("over-current trip wrong");
    a_cold_hold: assert property (ambientLow |=> !runPermit)
        else $error("run permitted while cold");
    a_key_clear: assert property (s_clearable ##0 $rose(stopKey)
        |=> !tripped && faultCode == 8'h00)
        else $error("key reset not taken");
    a_bus_clear: assert property (s_clearable ##0
        (fieldbusMode && $rose(ctrlResetBit)) |=> !tripped)
        else $error("control bit reset not taken");
    a_bus_ignored: assert property (tripped && !fieldbusMode &&
        !$rose(stopKey) && !$rose(driveEnable) |=> tripped)
        else $error("trip cleared without request");
endmodule : ftm_trip_monitor
bind ftm_fault_trip_manager ftm_trip_monitor ftm_trip_monitor_i (.*);

// File: testbench/ftm_host_model.sv
`timescale 1ns/10ps
module ftm_host_model (
    input wire logic mclk,
    input wire logic pollOn,
    output logic serialPoll = 1'b0,
    output logic canCyclic = 1'b0,
    output logic stopKey = 1'b0,
    output logic ctrlResetBit = 1'b0
);
    logic [2:0] gapCnt = 3'h0;
    // Poll every 8 cycles while enabled
    always @(posedge mclk)
    begin
        gapCnt <= gapCnt + 3'h1;
        serialPoll <= pollOn && gapCnt == 3'h0;
        canCyclic <= pollOn && gapCnt == 3'h0;
    end
    // Key press or control bit, 0 to 1, held 3 cycles
    task automatic pulse(input bit key);
        @(posedge mclk);
        if (key) stopKey <= 1'b1;
        else ctrlResetBit <= 1'b1;
        repeat (3) @(posedge mclk);
        {stopKey, ctrlResetBit} <= 2'h0;
    endtask : pulse
endmodule : ftm_host_model

// File: testbench/tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    localparam int MSC = 4;
    localparam logic [7:0] cd [12] = '{8'h09, 8'h0B, 8'h0D, 8'h0E,
        8'h10, 8'h11, 8'h13, 8'h15, 8'h16, 8'h17, 8'h1A, 8'h29};
    logic mclk = 1'b0, resetn = 1'b0, en = 1'b1, fbm = 1'b0;
    logic pollOn = 1'b0;
    logic [1:0] comm = 2'h0;
    logic [2:0] hv = 3'h0;
    logic [11:0] flt = 12'h000;
    logic [15:0] tmo = 16'h0000;
    logic serialPoll, canCyclic, stopKey, ctrlResetBit;
    logic tripped, driveStop, runPermit, holdOffActive;
    logic [7:0] faultCode;
    int n_fail = 0, checks_done = 0, cycNow = 0;
    initial
    begin
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) cycNow <= cycNow + 1;
    ftm_host_model ftm_host_model_i (.mclk(mclk), .pollOn(pollOn),
        .serialPoll(serialPoll), .canCyclic(canCyclic),
        .stopKey(stopKey), .ctrlResetBit(ctrlResetBit));
    ftm_fault_trip_manager #(.MS_CYCLES(MSC)) ftm_fault_trip_manager_i (
        .mclk(mclk), .resetn(resetn), .overCurrent(hv[0]),
        .hwOverCurrent(hv[1]), .motorOverload(hv[2]), .ambientLow(flt[0]),
        .din3Closed(!flt[1]), .busRippleHigh(flt[2]),
        .inputPhaseLost(flt[3]), .heatsinkSensorBad(flt[4]),
        .memFaultIo(flt[5]), .memFaultDsp(flt[6]), .motorPtcHot(flt[7]),
        .fanFailed(flt[8]), .internalHot(flt[9]),
        .outputPhaseBad(flt[10]), .tuningBad(flt[11]),
        .serialActive(comm[0]), .serialPoll(serialPoll),
        .canActive(comm[1]), .canCyclic(canCyclic), .commTimeoutMs(tmo),
        .driveEnable(en), .stopKey(stopKey), .fieldbusMode(fbm),
        .ctrlResetBit(ctrlResetBit), .tripped(tripped),
        .faultCode(faultCode), .driveStop(driveStop),
        .runPermit(runPermit), .holdOffActive(holdOffActive));
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test
    // Reset by key, enable toggle or control bit
    task automatic clear_via(input int k);
        if (k == 1)
        begin
            cyc(1); en <= 1'b0; cyc(2); en <= 1'b1;
        end
        else
            ftm_host_model_i.pulse(k == 0);
        cyc(2); @(negedge mclk);
        `CHK({tripped, faultCode, runPermit}, 10'h001)
    endtask : clear_via
    task automatic code_trip(input int i);
        cyc(1); flt[i] <= 1'b1; cyc(2); @(negedge mclk);
        `CHK(faultCode, cd[i])
        `CHK({driveStop, runPermit}, 2'h2)
        cyc(1); flt[i] <= 1'b0; clear_via(i % 3);
    endtask : code_trip
    // Over-current class trip, measured hold-off
    task automatic hold_trip(input int b, input int ms, input logic [7:0] c);
        int t0;
        int n;
        cyc(1); hv[b] <= 1'b1; cyc(1); hv <= 3'h0; t0 = cycNow;
        cyc(1); @(negedge mclk);
        `CHK({faultCode, holdOffActive}, {c, 1'b1})
        ftm_host_model_i.pulse(1'b1); cyc(2); @(negedge mclk);
        `CHK(tripped, 1'b1)
        for (n = 0; holdOffActive !== 1'b0 && n < 20000; n++)
            @(negedge mclk);
        if (n == 20000)
        begin
            n_fail++; finish_test();
        end
        n = cycNow - t0;
        `CHK(n >= ms * MSC && n <= (ms + 2) * MSC + 4, 1'b1)
        clear_via(0);
    endtask : hold_trip
    initial
    begin
        cyc(3); resetn <= 1'b1; fbm <= 1'b1;
        for (int i = 0; i < 12; i++)
            code_trip(i);
        cyc(1); flt[11] <= 1'b1; cyc(1); flt[5] <= 1'b1;
        cyc(2); @(negedge mclk);
        `CHK(faultCode, 8'h29)
        cyc(1); flt <= 12'h000; fbm <= 1'b0; ftm_host_model_i.pulse(1'b0);
        cyc(2); @(negedge mclk);
        `CHK(tripped, 1'b1)
        cyc(1); fbm <= 1'b1; clear_via(2);
        $display("code table test done");
        hold_trip(0, 2000, 8'h03);
        hold_trip(1, 4000, 8'h0F);
        cyc(1); resetn <= 1'b0; cyc(3); resetn <= 1'b1;
        hold_trip(2, 2000, 8'h04);
        $display("hold-off test done");
        cyc(1); tmo <= 16'h0005;
        for (int k = 0; k < 2; k++)
        begin
            cyc(1); comm <= 2'(1 << k); pollOn <= 1'b1;
            cyc(120); @(negedge mclk);
            `CHK(tripped, 1'b0)
            cyc(1); pollOn <= 1'b0; cyc(40); @(negedge mclk);
            `CHK(faultCode, 8'h32 + 8'(k))
            cyc(1); comm <= 2'h0; clear_via(0);
        end
        $display("watchdog test done");
        finish_test();
    end
endmodule : tb
